/* File: core/xps_pkg.sv */
// Purpose: Shared constants and types for the crosspoint switch control.
// Assumes: Bit-serial link sampled by the core clock.
// Notes: Switch index is 4*crosspoint + {AA,AB,BA,BB}.
package xps_pkg;
   localparam int NUM_XP = 3;
   localparam int SW_PER_XP = 4;
   localparam int NUM_SW = 12;
   localparam int NUM_GPO = 2;
   // Fixed upper address bits, pins fill the low three
   localparam logic [3:0] ADDR_FIXED = 4'ha;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Command byte layout
   localparam int CMD_LEVEL_BIT = 7;
   localparam logic [6:0] CMD_ALL_DIRECT = 7'h60;
   localparam logic [6:0] CMD_ALL_CROSS = 7'h61;
   localparam logic [6:0] CMD_SRC_A = 7'h62;
   localparam logic [6:0] CMD_SRC_B = 7'h63;
   localparam logic [6:0] CMD_DRN_A = 7'h64;
   localparam logic [6:0] CMD_DRN_B = 7'h65;
   localparam logic [6:0] CMD_SINGLE_FIRST = 7'h66;
   localparam logic [6:0] CMD_SINGLE_LAST = 7'h71;
   localparam logic [6:0] CMD_DIS_FIRST = 7'h72;
   localparam logic [6:0] CMD_DIS_LAST = 7'h74;
   localparam logic [6:0] CMD_GPO_FIRST = 7'h75;
   localparam logic [6:0] CMD_GPO_LAST = 7'h76;
   // Per-crosspoint switch groups
   localparam logic [3:0] GRP_DIRECT = 4'h9;
   localparam logic [3:0] GRP_CROSS = 4'h6;
   localparam logic [3:0] GRP_SRC_A = 4'h3;
   localparam logic [3:0] GRP_SRC_B = 4'hc;
   localparam logic [3:0] GRP_DRN_A = 4'h5;
   localparam logic [3:0] GRP_DRN_B = 4'ha;
   // Control byte layout
   localparam int CTL_LOAD_BIT = 1;
   localparam int CTL_RESET_BIT = 0;
   // Reset values
   localparam logic [11:0] SW_RST = 12'h000;
   localparam logic [1:0] GPO_RST = 2'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_A, ST_WR, ST_ACK_W, ST_RD, ST_ACK_R
   } xps_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } xps_line_t;
endpackage

/* File: core/xps_switch_ctrl.sv */
// Purpose: Serial slave that sets crosspoint switches and logic outputs.
// Assumes: Link lines are sampled by clk_i, far faster than the link.
// Notes: Pending states go live only when the load bit falls.
// Function
// - Slave only, never drives the clock
// - Detect data fall while clock high
// - Shift seven address bits then direction
// - Acknowledge own address on ninth pulse
// - Other address: stay silent until start
// - Direction one reads, zero writes
// - Nine pulses per byte with acknowledge
// - Data changes only while clock low
// - Data rise while clock high ends transfer
// - Address is 1010 then three pins
// - Each switch settable and readable back
// - Two logic outputs set by command
// - Switches applied on load bit fall
// - Outputs applied on load bit fall
// - Write carries two-byte word
// - Command byte then control byte
// - Latest command per element wins
`timescale 1ns/1ps
module xps_switch_ctrl
   import xps_pkg::*;
#(
   parameter bit HAS_GPO = 1'b1
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [2:0] addr_pin_i,
   output logic [NUM_SW-1:0] switch_on_o,
   output logic [NUM_GPO-1:0] general_output_o
);
   xps_line_t line_s1_q;
   xps_line_t line_s2_q;
   xps_line_t line_s3_q;
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   xps_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic byte_idx_q;
   logic rd_idx_q;
   logic nack_q;
   logic oe_q;
   logic cmd_stb;
   logic ctl_stb;
   logic [7:0] rx_byte;
   logic [6:0] own_addr;
   logic [NUM_SW-1:0] pend_sw_q;
   logic [NUM_GPO-1:0] pend_gpo_q;
   logic [NUM_SW-1:0] sw_q;
   logic [NUM_GPO-1:0] gpo_q;
   logic load_q;
   logic [NUM_SW-1:0] sw_mask;
   logic [NUM_GPO-1:0] gpo_mask;
   logic [3:0] grp;
   logic [6:0] code;
   logic level;
   logic [3:0] single_idx;
   logic [1:0] dis_idx;
   logic gpo_idx;

   // Two flops per outside input; stage three only feeds edge detection
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         line_s1_q <= '{scl: 1'b1, sda: 1'b1};
         line_s2_q <= '{scl: 1'b1, sda: 1'b1};
         line_s3_q <= '{scl: 1'b1, sda: 1'b1};
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         line_s1_q <= '{scl: scl_i, sda: sda_i};
         line_s2_q <= line_s1_q;
         line_s3_q <= line_s2_q;
         pin_s1_q <= addr_pin_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Clock edges and bus conditions from the synchronised lines
   assign scl_rise = line_s2_q.scl & ~line_s3_q.scl;
   assign scl_fall = ~line_s2_q.scl & line_s3_q.scl;
   assign start_det = line_s2_q.scl & line_s3_q.scl &
                      line_s3_q.sda & ~line_s2_q.sda;
   assign stop_det = line_s2_q.scl & line_s3_q.scl &
                     ~line_s3_q.sda & line_s2_q.sda;
   assign own_addr = {ADDR_FIXED, pin_s2_q};
   assign rx_byte = rx_q;

   // Open drain: only ever pull low, the clock line has no driver
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_q;

   // Strobes for the byte handler, raised at the end of the 8th bit
   assign cmd_stb = (state_q == ST_WR) && scl_fall &&
                    (cnt_q == BITS_PER_BYTE) && !byte_idx_q;
   assign ctl_stb = (state_q == ST_WR) && scl_fall &&
                    (cnt_q == BITS_PER_BYTE) && byte_idx_q;

   // Link state machine; outputs only change after a clock fall
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         rx_q <= BYTE_RST;
         tx_q <= BYTE_RST;
         rw_q <= 1'b0;
         byte_idx_q <= 1'b0;
         rd_idx_q <= 1'b0;
         nack_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (start_det) begin
         // A start aborts any byte in flight; partial bytes are lost
         state_q <= ST_ADDR;
         cnt_q <= 4'h0;
         oe_q <= 1'b0;
         byte_idx_q <= 1'b0;
         rd_idx_q <= 1'b0;
      end else if (stop_det) begin
         state_q <= ST_IDLE;
         oe_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               oe_q <= 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  rx_q <= {rx_q[6:0], line_s2_q.sda};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  rw_q <= rx_q[0];
                  if (rx_q[7:1] == own_addr) begin
                     state_q <= ST_ACK_A;
                     oe_q <= 1'b1;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_ACK_A: begin
               if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     state_q <= ST_RD;
                     tx_q <= switch_on_o[7:0];
                     oe_q <= ~switch_on_o[7];
                  end else begin
                     state_q <= ST_WR;
                     oe_q <= 1'b0;
                  end
               end
            end
            ST_WR: begin
               if (scl_rise) begin
                  rx_q <= {rx_q[6:0], line_s2_q.sda};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  state_q <= ST_ACK_W;
                  oe_q <= 1'b1;
               end
            end
            ST_ACK_W: begin
               if (scl_fall) begin
                  state_q <= ST_WR;
                  cnt_q <= 4'h0;
                  oe_q <= 1'b0;
                  byte_idx_q <= ~byte_idx_q;
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     state_q <= ST_ACK_R;
                     oe_q <= 1'b0;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     oe_q <= ~tx_q[6];
                  end
               end
            end
            ST_ACK_R: begin
               if (scl_rise) begin
                  nack_q <= line_s2_q.sda;
               end else if (scl_fall) begin
                  cnt_q <= 4'h0;
                  if (nack_q) begin
                     state_q <= ST_IDLE;
                  end else begin
                     // Alternate low and high status bytes
                     state_q <= ST_RD;
                     rd_idx_q <= ~rd_idx_q;
                     if (rd_idx_q) begin
                        tx_q <= switch_on_o[7:0];
                        oe_q <= ~switch_on_o[7];
                     end else begin
                        tx_q <= {4'h0, switch_on_o[11:8]};
                        oe_q <= 1'b1;
                     end
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               oe_q <= 1'b0;
            end
         endcase
      end
   end

   // Command decode into element masks; disables force off
   always_comb begin
      code = rx_byte[6:0];
      level = rx_byte[CMD_LEVEL_BIT];
      single_idx = 4'(code - CMD_SINGLE_FIRST);
      dis_idx = 2'(code - CMD_DIS_FIRST);
      gpo_idx = 1'(code - CMD_GPO_FIRST);
      sw_mask = '0;
      gpo_mask = '0;
      // Codes outside the table leave both masks empty and change nothing
      case (code)
         CMD_ALL_DIRECT: grp = GRP_DIRECT;
         CMD_ALL_CROSS: grp = GRP_CROSS;
         CMD_SRC_A: grp = GRP_SRC_A;
         CMD_SRC_B: grp = GRP_SRC_B;
         CMD_DRN_A: grp = GRP_DRN_A;
         CMD_DRN_B: grp = GRP_DRN_B;
         default: grp = 4'h0;
      endcase
      sw_mask = {NUM_XP{grp}};
      if (code >= CMD_SINGLE_FIRST && code <= CMD_SINGLE_LAST) begin
         sw_mask[single_idx] = 1'b1;
      end
      if (code >= CMD_DIS_FIRST && code <= CMD_DIS_LAST) begin
         sw_mask[{dis_idx, 2'b00} +: SW_PER_XP] = 4'hf;
         level = 1'b0;
      end
      if (HAS_GPO && code >= CMD_GPO_FIRST && code <= CMD_GPO_LAST) begin
         gpo_mask[gpo_idx] = 1'b1;
      end
   end

   // Pending states: a later command simply overwrites its elements
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pend_sw_q <= SW_RST;
         pend_gpo_q <= GPO_RST;
      end else if (ctl_stb && !rx_byte[CTL_RESET_BIT]) begin
         pend_sw_q <= SW_RST;
         pend_gpo_q <= GPO_RST;
      end else if (cmd_stb) begin
         pend_sw_q <= (pend_sw_q & ~sw_mask) |
                      (sw_mask & {NUM_SW{level}});
         pend_gpo_q <= (pend_gpo_q & ~gpo_mask) |
                       (gpo_mask & {NUM_GPO{level}});
      end
   end

   // Live states change on a one-to-zero step of the load bit, and clear when the reset bit is zero.
   // Holding the bit high lets several words queue up first.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         load_q <= 1'b0;
         sw_q <= SW_RST;
         gpo_q <= GPO_RST;
      end else if (ctl_stb) begin
         if (!rx_byte[CTL_RESET_BIT]) begin
            load_q <= 1'b0;
            sw_q <= SW_RST;
            gpo_q <= GPO_RST;
         end else begin
            load_q <= rx_byte[CTL_LOAD_BIT];
            if (load_q && !rx_byte[CTL_LOAD_BIT]) begin
               sw_q <= pend_sw_q;
               gpo_q <= HAS_GPO ? pend_gpo_q : GPO_RST;
            end
         end
      end
   end

   // Outputs come straight from the live flops, never from pending ones
   assign switch_on_o = sw_q;
   assign general_output_o = gpo_q;
endmodule

/* File: test/xps_switch_ctrl_chk.sv */
// Purpose: Port-level checks for the crosspoint switch control.
// Assumes: Link lines are raw, the master paces them slowly.
// Notes: Bound inside the bench top file.
`timescale 1ns/1ps
module xps_switch_ctrl_chk
   import xps_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [2:0] addr_pin_i,
   input wire logic [NUM_SW-1:0] switch_on_o,
   input wire logic [NUM_GPO-1:0] general_output_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Line events; the device can only pull data low
   sequence s_start; scl_i && $fell(sda_i); endsequence
   sequence s_stop; scl_i && $rose(sda_i); endsequence
   a_pull_only: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   a_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data moved while clock high");
   a_sw_clk_low: assert property ($changed(switch_on_o) |-> !scl_i)
      else $error("switches moved while clock high");
   a_gpo_clk_low: assert property ($changed(general_output_o) |-> !scl_i)
      else $error("outputs moved while clock high");
   a_pull_holds: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
      else $error("pull-low too short");
   a_stop_frees: assert property (s_stop |=> !sda_oe_o[*8])
      else $error("data driven after stop");
   a_start_frees: assert property (s_start |=> !sda_oe_o[*8])
      else $error("data driven during address");
   a_reset_idle: assert property ($rose(nrst_i) |-> !sda_oe_o[*3])
      else $error("data driven after reset");
endmodule

/* File: test/xps_master.sv */
// Purpose: Bus master model for the serial link.
// Assumes: A 125 ns bit, free-running against the core clock.
// Notes: Bit data changes only while the clock is low; start and stop move it while the clock is high.
`timescale 1ns/1ps
module xps_master (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // Both lines released at time zero
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Quarter bit; unrelated to the core clock so the sampling point drifts
   localparam real QUARTER_NS = 31.25;
   task automatic tk();
      #(QUARTER_NS);
   endtask
   // Data falls while the clock is high
   task automatic start();
      sda_o <= 1'b1;
      scl_o <= 1'b1;
      tk();
      sda_o <= 1'b0;
      tk();
      scl_o <= 1'b0;
      tk();
   endtask
   // Low before the tenth pulse, high during it
   task automatic stop();
      sda_o <= 1'b0;
      tk();
      scl_o <= 1'b1;
      tk();
      sda_o <= 1'b1;
      tk();
   endtask
   // One pulse; sample mid-high, so slow answers still land
   task automatic bitx(input logic b, output logic r);
      sda_o <= b;
      tk();
      scl_o <= 1'b1;
      tk();
      r = sda_i;
      tk();
      scl_o <= 1'b0;
      tk();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bitx(1'b1, r);
         d = {d[6:0], r};
      end
      bitx(last, r);
   endtask
endmodule

/* File: test/xps_switch_ctrl_test.sv */
// Purpose: Self-checking bench for the crosspoint switch control.
// Assumes: Master model runs a 125 ns bit, asynchronous to the core.
// Notes: Reference model keeps pending and live states.
`timescale 1ns/1ps
module xps_switch_ctrl_test
   import xps_pkg::*;
;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [2:0] pins = 3'h0;
   logic scl, sda_m, sda_w, sda_o, sda_oe;
   logic [NUM_SW-1:0] sw, m_pend = '0, m_live = '0;
   logic [NUM_GPO-1:0] general_output, g_pend = '0, g_live = '0;
   logic m_ld = 1'b0;
   logic [3:0] grp [6] = '{GRP_DIRECT, GRP_CROSS, GRP_SRC_A, GRP_SRC_B,
      GRP_DRN_A, GRP_DRN_B};
   int err_count = 0;
   int n_tests = 0;
   integer seed = 32'h2087;
   always #4 clk_i = ~clk_i;
   // Open-drain data line with pull-up
   assign sda_w = sda_oe ? (sda_m & sda_o) : sda_m;
   xps_master u_m (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
   xps_switch_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_pin_i(pins),
      .switch_on_o(sw), .general_output_o(general_output));
   task automatic chk(input string nm, input logic [11:0] s, e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Reference: decode command, then control byte
   task automatic model(input logic [7:0] cmd, ctl);
      logic [6:0] c;
      logic [11:0] m;
      logic lv;
      c = cmd[6:0];
      lv = cmd[CMD_LEVEL_BIT];
      m = '0;
      if (c >= CMD_ALL_DIRECT && c <= CMD_DRN_B) m = {3{grp[c - 7'h60]}};
      if (c >= CMD_SINGLE_FIRST && c <= CMD_SINGLE_LAST)
         m = 12'h1 << (c - CMD_SINGLE_FIRST);
      if (c >= CMD_DIS_FIRST && c <= CMD_DIS_LAST) begin
         m = 12'hf << 4 * (c - CMD_DIS_FIRST);
         lv = 1'b0;
      end
      if (c >= CMD_GPO_FIRST && c <= CMD_GPO_LAST) g_pend[c - 7'h75] = lv;
      m_pend = lv ? m_pend | m : m_pend & ~m;
      if (!ctl[CTL_RESET_BIT]) begin
         {m_pend, m_live, g_pend, g_live, m_ld} = '0;
      end else begin
         if (m_ld && !ctl[CTL_LOAD_BIT]) {m_live, g_live} = {m_pend, g_pend};
         m_ld = ctl[CTL_LOAD_BIT];
      end
   endtask
   // Whole write; a foreign address must see no acknowledge
   task automatic wr(input logic [6:0] a, input logic [7:0] cmd, ctl,
      input logic ok);
      logic k;
      u_m.start();
      u_m.wbyte({a, 1'b0}, k);
      chk("addr ack", 12'(k), 12'(ok));
      u_m.wbyte(cmd, k);
      chk("cmd ack", 12'(k), 12'(ok));
      u_m.wbyte(ctl, k);
      chk("ctl ack", 12'(k), 12'(ok));
      if (ok) model(cmd, ctl);
      u_m.stop();
      chk("switches", sw, m_live);
      chk("outputs", 12'(general_output), 12'(g_live));
   endtask
   task automatic rd(input logic [6:0] a);
      logic k;
      logic [7:0] d;
      logic [7:0] exp_q [$];
      // Expected read-back bytes, low switches first
      exp_q.push_back(m_live[7:0]);
      exp_q.push_back({4'h0, m_live[11:8]});
      u_m.start();
      u_m.wbyte({a, 1'b1}, k);
      chk("rd ack", 12'(k), 12'h1);
      u_m.rbyte(1'b0, d);
      chk("rd low", 12'(d), 12'(exp_q.pop_front()));
      u_m.rbyte(1'b1, d);
      chk("rd high", 12'(d), 12'(exp_q.pop_front()));
      u_m.stop();
   endtask
   task automatic print_verdict();
      if (err_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Every code once per pass, but 0x63, 0x6b and 0x73 go only to a foreign address; loads alternate so the load bit falls
   initial begin
      logic [7:0] c;
      logic [6:0] a;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("reset", sw, '0);
      for (int i = 0; i < 48; i++) begin
         @(posedge clk_i);
         c = 8'($random(seed));
         pins <= c[2:0];
         a = {ADDR_FIXED, c[2:0]};
         if (i % 8 == 3) a = a ^ (7'h1 << (i / 8));
         wr(a, {c[7], 7'(i % 24 + 'h60)}, i % 6 == 5 ? 8'h02 :
            (i % 2 == 1 ? 8'h01 : 8'h03), i % 8 != 3);
         rd({ADDR_FIXED, c[2:0]});
      end
      print_verdict();
   end
   // Watchdog cuts a hang short; about twice the 43000 clocks of the tests
   initial begin
      repeat (90000) @(posedge clk_i);
      err_count++;
      print_verdict();
   end
endmodule
bind xps_switch_ctrl xps_switch_ctrl_chk u_chk (.clk_i(clk_i),
   .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .addr_pin_i(addr_pin_i), .switch_on_o(switch_on_o),
   .general_output_o(general_output_o));
